// [tlsm_top.sv]
// Function
// RULE1 - bit 11 one when multiframes misaligned
// RULE2 - phase fields meaningful in subclass two only
// RULE3 - measure sync release against local multiframe
// RULE4 - interrupt on sync error or reinit
// RULE5 - offset, direction, count latched together
// RULE6 - raw phase only, software corrects
// RULE7 - bits 10:3 ilas multiframe count minus one
// RULE8 - bits 2:1 link layer state code
// RULE9 - bit 0 mirrors internal sync level
// RULE10 - fifo empty flags at bits 23:16
// RULE11 - fifo full flags at bits 7:0
// RULE12 - read-only live monitors, reserved zero
// RULE13 - bit 12 direction: advance or delay
// RULE14 - bits 20:13 adjustment step count
// RULE15 - unused lane flags read zero
//
// The implementer's own choice: the Wishbone slave port.
`timescale 1ns/1ps
module tlsm_top (
  input wire logic clk,
  input wire logic reset_n,
  // wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // link side monitor inputs
  input wire logic dev_sync_n,
  input wire logic [1:0] link_state,
  input wire logic [tlsm_pkg::TLSM_ILAS_W-1:0] ilas_mf_count,
  input wire logic [tlsm_pkg::TLSM_LMFC_W-1:0] lmfc_count,
  input wire logic [tlsm_pkg::TLSM_LMFC_W-1:0] lmfc_period,
  input wire logic sync_reinit_req,
  input wire logic [tlsm_pkg::TLSM_LANES-1:0] lane_en,
  input wire logic [tlsm_pkg::TLSM_LANES-1:0] lane_fifo_empty_flag,
  input wire logic [tlsm_pkg::TLSM_LANES-1:0] lane_fifo_full_flag,
  output logic irq
);
  typedef struct packed {
    logic [31:0] rdata; // bus read data
    logic ack; // bus acknowledge
    logic irq; // interrupt level
    logic [1:0] subclass; // software subclass select
    logic [tlsm_pkg::TLSM_ERR_W-1:0] err; // sticky error flags
    logic [tlsm_pkg::TLSM_ERR_W-1:0] mask; // interrupt enables
    logic [31:0] dbg; // assembled debug word
    logic sync_d; // sync level last cycle, for error edge
  } tlsm_st_t;
  tlsm_st_t st_r; // registered state
  tlsm_st_t st_nxt; // next state

  logic sc2; // subclass two active
  logic pd_phadj; // misalignment flag
  logic pd_adjdir; // direction flag
  logic [tlsm_pkg::TLSM_CNT_W-1:0] pd_adjcnt; // step count
  logic pd_meas; // one-cycle measurement strobe
  logic [31:0] fifo_word; // lane fifo flag word
  logic bus_req; // valid new wishbone cycle
  logic [tlsm_pkg::TLSM_ERR_W-1:0] err_set; // hardware error events
  logic [tlsm_pkg::TLSM_ERR_W-1:0] err_clr; // software write-one clears
  logic [tlsm_pkg::TLSM_ERR_W-1:0] err_tmp; // error flags after update

  assign sc2 = (st_r.subclass == tlsm_pkg::TLSM_SUBCLASS_TWO);

  // RULE3 phase detector
  // RULE2 runs in subclass two only
  tlsm_phase_det u_phase (
    .clk(clk),
    .reset_n(reset_n),
    .sync_n(dev_sync_n),
    .lmfc_count(lmfc_count),
    .lmfc_period(lmfc_period),
    .enable(sc2),
    .phadj(pd_phadj),
    .adjdir(pd_adjdir),
    .adjcnt(pd_adjcnt),
    .meas_pulse(pd_meas)
  );

  // per-lane fifo flag sampler
  tlsm_lane_flags u_lanes (
    .clk(clk),
    .reset_n(reset_n),
    .lane_en(lane_en),
    .lane_fifo_empty_flag(lane_fifo_empty_flag),
    .lane_fifo_full_flag(lane_fifo_full_flag),
    .flags_word(fifo_word)
  );

  // a fresh request; ack high blocks the next so each access answers once
  assign bus_req = wb_cyc_i && wb_stb_i && !st_r.ack;

  // next-state logic: debug word, errors, interrupt and bus slave
  always_comb begin
    st_nxt = st_r;
    st_nxt.sync_d = dev_sync_n;
    // RULE12 debug word tracks live signals, reserved zero
    st_nxt.dbg = tlsm_pkg::TLSM_ZERO32;
    // RULE9 sync level mirror
    st_nxt.dbg[tlsm_pkg::TLSM_DBG_SYNC_BIT] = dev_sync_n;
    // RULE8 link layer state
    st_nxt.dbg[tlsm_pkg::TLSM_DBG_STATE_LSB +: 2] = link_state;
    // RULE7 ilas count minus one
    st_nxt.dbg[tlsm_pkg::TLSM_DBG_ILAS_LSB +: tlsm_pkg::TLSM_ILAS_W] = ilas_mf_count;
    if (sc2) begin
      // RULE1 misalignment flag
      st_nxt.dbg[tlsm_pkg::TLSM_DBG_PHADJ_BIT] = pd_phadj;
      // RULE13 adjust direction
      st_nxt.dbg[tlsm_pkg::TLSM_DBG_DIR_BIT] = pd_adjdir;
      // RULE14 adjust step count
      // RULE5 fields latched together
      // RULE6 raw count, no correction
      st_nxt.dbg[tlsm_pkg::TLSM_DBG_CNT_LSB +: tlsm_pkg::TLSM_CNT_W] = pd_adjcnt;
    end

    // error events: sync dropped during data or misaligned release, and reinit
    err_set = '0;
    err_set[tlsm_pkg::TLSM_ERR_SYNC_BIT] = (st_r.sync_d && !dev_sync_n && link_state[1])
                                           || (pd_meas && pd_phadj);
    err_set[tlsm_pkg::TLSM_ERR_REINIT_BIT] = sync_reinit_req;
    err_clr = '0;
    if (bus_req && wb_we_i && wb_sel_i[0] && wb_adr_i == tlsm_pkg::TLSM_OFS_ERR) begin
      err_clr = wb_dat_i[tlsm_pkg::TLSM_ERR_W-1:0];
    end
    // set wins over a clear in the same cycle
    err_tmp = ((st_r.err & ~err_clr) | err_set) & tlsm_pkg::TLSM_ERR_VALID;
    st_nxt.err = err_tmp;

    // mask and subclass writes
    if (bus_req && wb_we_i && wb_sel_i[0]) begin
      if (wb_adr_i == tlsm_pkg::TLSM_OFS_ERR_MASK) begin
        st_nxt.mask = wb_dat_i[tlsm_pkg::TLSM_ERR_W-1:0] & tlsm_pkg::TLSM_ERR_VALID;
      end
      if (wb_adr_i == tlsm_pkg::TLSM_OFS_CTRL) begin
        st_nxt.subclass = wb_dat_i[1:0];
      end
    end

    // RULE4 interrupt on unmasked errors
    st_nxt.irq = |(err_tmp & st_nxt.mask);

    // one-cycle ack; unmapped addresses read zero, writes ignored
    st_nxt.ack = bus_req;
    st_nxt.rdata = tlsm_pkg::TLSM_ZERO32;
    if (bus_req && !wb_we_i) begin
      case (wb_adr_i)
        tlsm_pkg::TLSM_OFS_ERR: begin
          st_nxt.rdata[tlsm_pkg::TLSM_ERR_W-1:0] = st_r.err;
        end
        tlsm_pkg::TLSM_OFS_ERR_MASK: begin
          st_nxt.rdata[tlsm_pkg::TLSM_ERR_W-1:0] = st_r.mask;
        end
        // RULE12 status words are read-only
        tlsm_pkg::TLSM_OFS_DEBUG: begin
          st_nxt.rdata = st_r.dbg;
        end
        tlsm_pkg::TLSM_OFS_FIFO: begin
          st_nxt.rdata = fifo_word;
        end
        tlsm_pkg::TLSM_OFS_CTRL: begin
          st_nxt.rdata[1:0] = st_r.subclass;
        end
        default: begin
          st_nxt.rdata = tlsm_pkg::TLSM_ZERO32;
        end
      endcase
    end
  end

  // state register, sync reset; mask defaults to sync and reinit enabled
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st_r <= '0;
      st_r.mask <= tlsm_pkg::TLSM_ERR_MASK_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign wb_dat_o = st_r.rdata;
  assign wb_ack_o = st_r.ack;
  assign irq = st_r.irq;
endmodule : tlsm_top

// [tlsm_pkg.sv]
package tlsm_pkg;
  // register byte offsets
  localparam logic [7:0] TLSM_OFS_ERR = 8'h60; // sticky transmit error status, write one to clear
  localparam logic [7:0] TLSM_OFS_ERR_MASK = 8'h64; // interrupt enable mask
  localparam logic [7:0] TLSM_OFS_DEBUG = 8'h80; // link state debug word
  localparam logic [7:0] TLSM_OFS_FIFO = 8'h84; // lane fifo flag word
  localparam logic [7:0] TLSM_OFS_CTRL = 8'h88; // subclass select
  // field positions of the debug word
  localparam int TLSM_DBG_SYNC_BIT = 0;
  localparam int TLSM_DBG_STATE_LSB = 1;
  localparam int TLSM_DBG_ILAS_LSB = 3;
  localparam int TLSM_DBG_PHADJ_BIT = 11;
  localparam int TLSM_DBG_DIR_BIT = 12;
  localparam int TLSM_DBG_CNT_LSB = 13;
  // field positions of the fifo word
  localparam int TLSM_FULL_LSB = 0;
  localparam int TLSM_EMPTY_LSB = 16;
  // error bits
  localparam int TLSM_ERR_SYNC_BIT = 0;
  localparam int TLSM_ERR_REINIT_BIT = 4;
  // widths and sizes
  localparam int TLSM_LANES = 8;
  localparam int TLSM_ILAS_W = 8;
  localparam int TLSM_CNT_W = 8;
  localparam int TLSM_LMFC_W = 8;
  localparam int TLSM_ERR_W = 5;
  // reset and mask values
  localparam logic [31:0] TLSM_ZERO32 = 32'h0000_0000;
  localparam logic [TLSM_ERR_W-1:0] TLSM_ERR_MASK_RST = 5'h11;
  localparam logic [TLSM_ERR_W-1:0] TLSM_ERR_VALID = 5'h11;
  localparam logic [1:0] TLSM_SUBCLASS_TWO = 2'h2;
  localparam logic [TLSM_LMFC_W-1:0] TLSM_LMFC_ONE = 8'h01;
  localparam logic [TLSM_CNT_W-1:0] TLSM_CNT_ONE = 8'h01;
endpackage : tlsm_pkg

// [tlsm_phase_det.sv]
`timescale 1ns/1ps
// measures the sync release against the local multiframe counter
module tlsm_phase_det (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic sync_n,
  input wire logic [tlsm_pkg::TLSM_LMFC_W-1:0] lmfc_count,
  input wire logic [tlsm_pkg::TLSM_LMFC_W-1:0] lmfc_period,
  input wire logic enable,
  output logic phadj,
  output logic adjdir,
  output logic [tlsm_pkg::TLSM_CNT_W-1:0] adjcnt,
  output logic meas_pulse
);
  typedef struct packed {
    logic sync_d; // previous sync level, for release edge
    logic phadj;
    logic adjdir;
    logic [tlsm_pkg::TLSM_CNT_W-1:0] adjcnt;
    logic meas;
  } tlsm_pd_t;
  tlsm_pd_t st_r; // registered state
  tlsm_pd_t st_nxt; // next state
  logic [tlsm_pkg::TLSM_LMFC_W-1:0] back; // distance to tick ahead, less one

  // latch offset, direction and count together on release
  always_comb begin
    st_nxt = st_r;
    st_nxt.sync_d = sync_n;
    st_nxt.meas = 1'b0;
    back = lmfc_period - lmfc_count;
    // only raw link-clock phase, no hysteresis in hardware
    if (enable && sync_n && !st_r.sync_d) begin
      st_nxt.meas = 1'b1;
      st_nxt.phadj = (lmfc_count != '0);
      // nearest tick: advance when behind half way, else delay
      if (lmfc_count <= (lmfc_period >> 1)) begin
        st_nxt.adjdir = 1'b0;
        st_nxt.adjcnt = lmfc_count;
      end else begin
        st_nxt.adjdir = 1'b1;
        st_nxt.adjcnt = back + tlsm_pkg::TLSM_CNT_ONE;
      end
    end
  end

  // state register, sync reset to zero
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign phadj = st_r.phadj;
  assign adjdir = st_r.adjdir;
  assign adjcnt = st_r.adjcnt;
  assign meas_pulse = st_r.meas;
endmodule : tlsm_phase_det

// [tlsm_lane_flags.sv]
`timescale 1ns/1ps
// samples per-lane fifo flags, unused lanes forced to zero
module tlsm_lane_flags (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [tlsm_pkg::TLSM_LANES-1:0] lane_en,
  input wire logic [tlsm_pkg::TLSM_LANES-1:0] lane_fifo_empty_flag,
  input wire logic [tlsm_pkg::TLSM_LANES-1:0] lane_fifo_full_flag,
  output logic [31:0] flags_word
);
  typedef struct packed {
    logic [31:0] word; // assembled fifo flag word
  } tlsm_lf_t;
  tlsm_lf_t st_r;
  tlsm_lf_t st_nxt;

  // place each lane's flags, reserved bits stay zero
  always_comb begin
    st_nxt.word = tlsm_pkg::TLSM_ZERO32;
    for (int i = 0; i < tlsm_pkg::TLSM_LANES; i++) begin
      // RULE10 empty at bit 16 plus lane
      st_nxt.word[tlsm_pkg::TLSM_EMPTY_LSB + i] = lane_en[i] & lane_fifo_empty_flag[i];
      // RULE11 full at lane bit
      // RULE15 absent lanes read zero
      st_nxt.word[tlsm_pkg::TLSM_FULL_LSB + i] = lane_en[i] & lane_fifo_full_flag[i];
    end
  end

  // RULE12 sampled live, reset to zero
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign flags_word = st_r.word;
endmodule : tlsm_lane_flags

// [tlsm_assertions.sv]
`timescale 1ns/1ps
// watches the register port and the monitor inputs of the top module
module tlsm_assertions (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic dev_sync_n,
  input wire logic [1:0] link_state,
  input wire logic [tlsm_pkg::TLSM_ILAS_W-1:0] ilas_mf_count,
  input wire logic sync_reinit_req,
  input wire logic [tlsm_pkg::TLSM_LANES-1:0] lane_en,
  input wire logic [tlsm_pkg::TLSM_LANES-1:0] lane_fifo_empty_flag,
  input wire logic [tlsm_pkg::TLSM_LANES-1:0] lane_fifo_full_flag,
  input wire logic irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // a request is taken only while no ack is out
  logic req;
  logic rd_fifo;
  logic rd_dbg;
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign rd_fifo = req && !wb_we_i && wb_adr_i == tlsm_pkg::TLSM_OFS_FIFO;
  assign rd_dbg = req && !wb_we_i && wb_adr_i == tlsm_pkg::TLSM_OFS_DEBUG;
  // read data lags the inputs by two edges, so reads right after reset are skipped
  a_ack_next_cycle: assert property (req |=> wb_ack_o)
    else $error("ack missing after request");
  a_ack_single_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_dat_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data not zero outside ack");
  a_fifo_full_map: assert property (rd_fifo && $past(reset_n, 2) |=>
    wb_dat_o[7:0] == $past(lane_fifo_full_flag & lane_en, 2))
    else $error("full flags misplaced");
  a_fifo_empty_map: assert property (rd_fifo && $past(reset_n, 2) |=>
    wb_dat_o[23:16] == $past(lane_fifo_empty_flag & lane_en, 2))
    else $error("empty flags misplaced");
  a_fifo_rsvd_zero: assert property (rd_fifo |=>
    wb_dat_o[31:24] == 8'h00 && wb_dat_o[15:8] == 8'h00)
    else $error("fifo word reserved bits set");
  a_dbg_low_fields: assert property (rd_dbg && $past(reset_n, 2) |=>
    wb_dat_o[10:0] == {$past(ilas_mf_count, 2), $past(link_state, 2), $past(dev_sync_n, 2)})
    else $error("debug low fields wrong");
  a_dbg_rsvd_zero: assert property (rd_dbg |=> wb_dat_o[31:21] == 11'h000)
    else $error("debug word reserved bits set");
  a_irq_on_reinit: assert property ($rose(sync_reinit_req) |-> ##[1:3] irq)
    else $error("no interrupt after reinit request");
  c_fifo_read: cover property (rd_fifo);
  c_dbg_read: cover property (rd_dbg);
  c_irq_rise: cover property ($rose(irq));
endmodule : tlsm_assertions

// [tlsm_top_tb.sv]
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin error_cnt++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module tlsm_top_tb;
  logic clk = 1'b0, reset_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic sync_n = 1'b0, reinit = 1'b0, ack, irq;
  logic [3:0] sel = 4'hf;
  logic [1:0] state = 2'h0;
  logic [7:0] adr = 8'h00, ilas = 8'h00, cnt = 8'h00, per = 8'h09;
  logic [7:0] en = 8'h00, emp = 8'h00, full = 8'h00;
  logic [31:0] wdat = 32'h0, rdat, q;
  int error_cnt = 0, checked = 0;
  // one row: monitor inputs, then the fifo and debug words they should give
  typedef struct packed {logic [7:0] en, emp, full; logic [1:0] st; logic [7:0] il;
    logic sy; logic [31:0] xf, xd;} tlsm_row_t;
  tlsm_row_t rows [4] = '{'{8'hff, 8'ha5, 8'h3c, 2'h0, 8'h00, 1'b0, 32'h00a5003c, 32'h0},
    '{8'h0f, 8'hff, 8'hff, 2'h1, 8'h03, 1'b1, 32'h000f000f, 32'h1b},
    '{8'h00, 8'hff, 8'hff, 2'h2, 8'hff, 1'b1, 32'h0, 32'h7fd},
    '{8'h81, 8'h01, 8'h80, 2'h3, 8'h80, 1'b1, 32'h00010080, 32'h407}};
  // multiframe positions at sync release and the debug word expected after
  logic [7:0] pc [3] = '{8'h03, 8'h07, 8'h00};
  logic [31:0] px [3] = '{32'h6801, 32'h7801, 32'h1};
  always #50 clk = ~clk;
  tlsm_top dut_u (.clk, .reset_n, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .dev_sync_n(sync_n), .link_state(state), .ilas_mf_count(ilas), .lmfc_count(cnt),
    .lmfc_period(per), .sync_reinit_req(reinit), .lane_en(en),
    .lane_fifo_empty_flag(emp), .lane_fifo_full_flag(full), .irq);
  // one classic cycle; the request stands until ack is seen at an edge
  // no cycle limit of its own: only the watchdog ends a hung wait
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    q = rdat;
    {cyc, stb, we} <= 3'b000;
  endtask : xfer
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    `CHK("read data", e, q)
  endtask : rd_chk
  task automatic irq_chk(input logic e);
    repeat (3) @(posedge clk);
    `CHK("irq", e, irq)
  endtask : irq_chk
  task give_verdict;
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (10) @(posedge clk);
    `CHK("ack in reset", 1'b0, ack)
    reset_n <= 1'b1;
    rd_chk(tlsm_pkg::TLSM_OFS_ERR_MASK, 32'h11);
    rd_chk(tlsm_pkg::TLSM_OFS_FIFO, 32'h0);
    rd_chk(8'hf0, 32'h0);
    $display("test reset done");
    // ordinary cases: every link state code and four lane patterns
    foreach (rows[i]) begin
      @(posedge clk);
      {en, emp, full, state, ilas, sync_n} <= rows[i][98:64];
      rd_chk(tlsm_pkg::TLSM_OFS_FIFO, rows[i].xf);
      rd_chk(tlsm_pkg::TLSM_OFS_DEBUG, rows[i].xd);
    end
    xfer(1'b1, tlsm_pkg::TLSM_OFS_FIFO, 32'hffffffff);
    rd_chk(tlsm_pkg::TLSM_OFS_FIFO, rows[3].xf);
    $display("test rows done");
    // subclass two measurement, sync error masked while it happens
    @(posedge clk);
    {state, ilas} <= 10'h0;
    xfer(1'b1, tlsm_pkg::TLSM_OFS_CTRL, 32'h2);
    xfer(1'b1, tlsm_pkg::TLSM_OFS_ERR_MASK, 32'h10);
    foreach (pc[i]) begin
      @(posedge clk);
      {cnt, sync_n} <= {pc[i], 1'b0};
      repeat (2) @(posedge clk);
      sync_n <= 1'b1;
      repeat (4) @(posedge clk);
      rd_chk(tlsm_pkg::TLSM_OFS_DEBUG, px[i]);
    end
    irq_chk(1'b0);
    rd_chk(tlsm_pkg::TLSM_OFS_ERR, 32'h1);
    // a write without byte lane 0 must leave the flags alone
    sel <= 4'he;
    xfer(1'b1, tlsm_pkg::TLSM_OFS_ERR, 32'h1);
    sel <= 4'hf;
    rd_chk(tlsm_pkg::TLSM_OFS_ERR, 32'h1);
    xfer(1'b1, tlsm_pkg::TLSM_OFS_CTRL, 32'h0);
    rd_chk(tlsm_pkg::TLSM_OFS_DEBUG, 32'h1);
    xfer(1'b1, tlsm_pkg::TLSM_OFS_ERR_MASK, 32'h11);
    irq_chk(1'b1);
    xfer(1'b1, tlsm_pkg::TLSM_OFS_ERR, 32'h1);
    irq_chk(1'b0);
    // a single-cycle reinit request must latch and interrupt
    @(posedge clk);
    reinit <= 1'b1;
    @(posedge clk);
    reinit <= 1'b0;
    irq_chk(1'b1);
    rd_chk(tlsm_pkg::TLSM_OFS_ERR, 32'h10);
    xfer(1'b1, tlsm_pkg::TLSM_OFS_ERR, 32'h10);
    irq_chk(1'b0);
    $display("test interrupt done");
    // mid-run reset: pending flag, changed mask and subclass all return to reset values
    @(posedge clk);
    reinit <= 1'b1;
    @(posedge clk);
    reinit <= 1'b0;
    xfer(1'b1, tlsm_pkg::TLSM_OFS_ERR_MASK, 32'h10);
    xfer(1'b1, tlsm_pkg::TLSM_OFS_CTRL, 32'h2);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK("irq in reset", 1'b0, irq)
    reset_n <= 1'b1;
    rd_chk(tlsm_pkg::TLSM_OFS_ERR, 32'h0);
    rd_chk(tlsm_pkg::TLSM_OFS_ERR_MASK, 32'h11);
    rd_chk(tlsm_pkg::TLSM_OFS_CTRL, 32'h0);
    $display("test second reset done");
    give_verdict;
  end
  // the whole sequence takes about 150 cycles
  initial begin
    repeat (2000) @(posedge clk);
    error_cnt++;
    give_verdict;
  end
endmodule : tlsm_top_tb
bind tlsm_top tlsm_assertions chk_u (.clk, .reset_n, .wb_cyc_i, .wb_stb_i, .wb_we_i,
  .wb_adr_i, .wb_dat_o, .wb_ack_o, .dev_sync_n, .link_state, .ilas_mf_count,
  .sync_reinit_req, .lane_en, .lane_fifo_empty_flag, .lane_fifo_full_flag, .irq);
